// ---- src/mjdc_pkg.sv ----
// Purpose: Shared constants for the multicore debug scan chain
// Assumes: One local clock for all cores in this model
// Notes:   Identity value below is arbitrary
package mjdc_pkg;
  localparam int unsigned NUM_CORES   = 18;
  localparam int unsigned IR_WIDTH    = 4;
  localparam int unsigned ID_WIDTH    = 32;
  // Arbitrary identity value, not tied to any real part
  localparam logic [31:0] ID_CODE     = 32'h1234_5671;
  localparam logic [3:0]  IR_IDCODE   = 4'he;
  localparam logic [3:0]  IR_BYPASS   = 4'hf;
  localparam logic [3:0]  IR_CAPTURE  = 4'h1;

  typedef enum logic [15:0] {
    ST_RESET   = 16'h0001,
    ST_IDLE    = 16'h0002,
    ST_SEL_DR  = 16'h0004,
    ST_CAP_DR  = 16'h0008,
    ST_SH_DR   = 16'h0010,
    ST_EX1_DR  = 16'h0020,
    ST_PA_DR   = 16'h0040,
    ST_EX2_DR  = 16'h0080,
    ST_UP_DR   = 16'h0100,
    ST_SEL_IR  = 16'h0200,
    ST_CAP_IR  = 16'h0400,
    ST_SH_IR   = 16'h0800,
    ST_EX1_IR  = 16'h1000,
    ST_PA_IR   = 16'h2000,
    ST_EX2_IR  = 16'h4000,
    ST_UP_IR   = 16'h8000
  } mjdc_state_type;
endpackage : mjdc_pkg

// ---- src/mjdc_core_tap.sv ----
// Purpose: One core's test access port, advanced on recognised clock edges
// Assumes: Edge strobes come from the synchronised test clock
// Notes:   Only identity and bypass data registers exist
`timescale 1ns/1ns
module mjdc_core_tap (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic trst_n_s,
  // Recognised test clock edges
  input  wire logic tck_rise,
  input  wire logic tck_fall,
  // Scan path
  input  wire logic tms,
  input  wire logic tdi,
  output logic      tdo
);
  mjdc_pkg::mjdc_state_type state_q;
  mjdc_pkg::mjdc_state_type state_d;
  logic [mjdc_pkg::IR_WIDTH-1:0] ir_q;
  logic [mjdc_pkg::IR_WIDTH-1:0] irsh_q;
  logic [mjdc_pkg::ID_WIDTH-1:0] dr_q;
  logic                          byp_q;

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      mjdc_pkg::ST_RESET:  state_d = tms ? mjdc_pkg::ST_RESET : mjdc_pkg::ST_IDLE;
      mjdc_pkg::ST_IDLE:   state_d = tms ? mjdc_pkg::ST_SEL_DR : mjdc_pkg::ST_IDLE;
      mjdc_pkg::ST_SEL_DR: state_d = tms ? mjdc_pkg::ST_SEL_IR : mjdc_pkg::ST_CAP_DR;
      mjdc_pkg::ST_CAP_DR: state_d = tms ? mjdc_pkg::ST_EX1_DR : mjdc_pkg::ST_SH_DR;
      mjdc_pkg::ST_SH_DR:  state_d = tms ? mjdc_pkg::ST_EX1_DR : mjdc_pkg::ST_SH_DR;
      mjdc_pkg::ST_EX1_DR: state_d = tms ? mjdc_pkg::ST_UP_DR : mjdc_pkg::ST_PA_DR;
      mjdc_pkg::ST_PA_DR:  state_d = tms ? mjdc_pkg::ST_EX2_DR : mjdc_pkg::ST_PA_DR;
      mjdc_pkg::ST_EX2_DR: state_d = tms ? mjdc_pkg::ST_UP_DR : mjdc_pkg::ST_SH_DR;
      mjdc_pkg::ST_UP_DR:  state_d = tms ? mjdc_pkg::ST_SEL_DR : mjdc_pkg::ST_IDLE;
      mjdc_pkg::ST_SEL_IR: state_d = tms ? mjdc_pkg::ST_RESET : mjdc_pkg::ST_CAP_IR;
      mjdc_pkg::ST_CAP_IR: state_d = tms ? mjdc_pkg::ST_EX1_IR : mjdc_pkg::ST_SH_IR;
      mjdc_pkg::ST_SH_IR:  state_d = tms ? mjdc_pkg::ST_EX1_IR : mjdc_pkg::ST_SH_IR;
      mjdc_pkg::ST_EX1_IR: state_d = tms ? mjdc_pkg::ST_UP_IR : mjdc_pkg::ST_PA_IR;
      mjdc_pkg::ST_PA_IR:  state_d = tms ? mjdc_pkg::ST_EX2_IR : mjdc_pkg::ST_PA_IR;
      mjdc_pkg::ST_EX2_IR: state_d = tms ? mjdc_pkg::ST_UP_IR : mjdc_pkg::ST_SH_IR;
      mjdc_pkg::ST_UP_IR:  state_d = tms ? mjdc_pkg::ST_SEL_DR : mjdc_pkg::ST_IDLE;
      default:             state_d = mjdc_pkg::ST_RESET;
    endcase
  end

  // Controller moves on recognised rising edges, or to reset while trst_n_s is low
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      state_q <= mjdc_pkg::ST_RESET;
    else if (!trst_n_s)
      state_q <= mjdc_pkg::ST_RESET;
    else if (tck_rise)
      state_q <= state_d;
  end

  // Instruction register; reset selects identity
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ir_q   <= mjdc_pkg::IR_IDCODE;
      irsh_q <= mjdc_pkg::IR_CAPTURE;
    end
    else if (!trst_n_s || (tck_rise && state_q == mjdc_pkg::ST_RESET))
    begin
      ir_q   <= mjdc_pkg::IR_IDCODE;
      irsh_q <= mjdc_pkg::IR_CAPTURE;
    end
    else if (tck_rise)
    begin
      if (state_q == mjdc_pkg::ST_CAP_IR)
        irsh_q <= mjdc_pkg::IR_CAPTURE;
      else if (state_q == mjdc_pkg::ST_SH_IR)
        irsh_q <= {tdi, irsh_q[mjdc_pkg::IR_WIDTH-1:1]};
      // Update happens on the falling edge per standard timing
    end
    else if (tck_fall && state_q == mjdc_pkg::ST_UP_IR)
      ir_q <= irsh_q;
  end

  // Data registers: identity and single-bit bypass; no boundary scan exists
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      dr_q  <= '0;
      byp_q <= 1'b0;
    end
    else if (tck_rise && state_q == mjdc_pkg::ST_CAP_DR)
    begin
      dr_q  <= mjdc_pkg::ID_CODE;
      byp_q <= 1'b0;
    end
    else if (tck_rise && state_q == mjdc_pkg::ST_SH_DR)
    begin
      if (ir_q == mjdc_pkg::IR_IDCODE)
        dr_q <= {tdi, dr_q[mjdc_pkg::ID_WIDTH-1:1]};
      else
        byp_q <= tdi;
    end
  end

  // Output changes on falling edge, as the standard requires
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tdo <= 1'b0;
    else if (tck_fall)
    begin
      if (state_q == mjdc_pkg::ST_SH_IR)
        tdo <= irsh_q[0];
      else if (state_q == mjdc_pkg::ST_SH_DR)
        tdo <= (ir_q == mjdc_pkg::IR_IDCODE) ? dr_q[0] : byp_q;
    end
  end
endmodule : mjdc_core_tap

// ---- src/mjdc_chain.sv ----
// Purpose: Debug scan chain of all cores with returned test clock
// Assumes: Probe waits on the returned clock before each test clock edge
// Notes:   Debug access only; no pin scan
`timescale 1ns/1ns
module mjdc_chain (
  // Clock and reset
  input  wire logic clk,
  input  wire logic arst_n,
  // Probe pins
  input  wire logic trst_n,
  input  wire logic tck,
  input  wire logic tms,
  input  wire logic tdi,
  output logic      return_test_clock,
  output logic      tdo
);
  // Pin synchronisers, two stages each
  logic [1:0] tck_sync_q;
  logic [1:0] tms_sync_q;
  logic [1:0] tdi_sync_q;
  logic [1:0] trst_sync_q;
  logic       tck_seen_q;
  logic       tck_rise;
  logic       tck_fall;
  logic [mjdc_pkg::NUM_CORES:0] link;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tck_sync_q  <= '0;
      tms_sync_q  <= 2'h3;
      tdi_sync_q  <= 2'h3;
      trst_sync_q <= '0;
    end
    else
    begin
      tck_sync_q  <= {tck_sync_q[0], tck};
      tms_sync_q  <= {tms_sync_q[0], tms};
      tdi_sync_q  <= {tdi_sync_q[0], tdi};
      trst_sync_q <= {trst_sync_q[0], trst_n};
    end
  end

  // Edge detection looks only at the second stage
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      tck_seen_q <= 1'b0;
    else
      tck_seen_q <= tck_sync_q[1];
  end

  // Mode and data were sampled alongside clock, so stable by handshake
  assign tck_rise = tck_sync_q[1] & ~tck_seen_q;
  assign tck_fall = ~tck_sync_q[1] & tck_seen_q;

  // Return clock follows only after the local logic has acted on the edge
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      return_test_clock <= 1'b0;
    else
      return_test_clock <= tck_seen_q;
  end

  assign link[0] = tdi_sync_q[1];

  // Core zero nearest the data input
  genvar g;
  generate
    for (g = 0; g < mjdc_pkg::NUM_CORES; g++)
    begin : g_core
      mjdc_core_tap u_tap (
        .clk      (clk),
        .arst_n   (arst_n),
        .trst_n_s (trst_sync_q[1]),
        .tck_rise (tck_rise),
        .tck_fall (tck_fall),
        .tms      (tms_sync_q[1]),
        .tdi      (link[g]),
        .tdo      (link[g+1])
      );
    end
  endgenerate

  assign tdo = link[mjdc_pkg::NUM_CORES];
endmodule : mjdc_chain

// ---- verif/mjdc_chain_asserts.sv ----
// Purpose: Port checks for the debug scan chain
// Assumes: Probe keeps the return clock handshake
// Notes:   Windows allow the synchroniser slack
`timescale 1ns/1ns
module mjdc_chain_asserts (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic trst_n,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  input wire logic return_test_clock,
  input wire logic tdo
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_up; $rose(tck); endsequence
  property p_up; s_up |-> ##[1:4] return_test_clock; endproperty
  a_up: assert property (p_up) else $error("return clock late on rise");
  property p_dn; $fell(tck) |-> ##[1:4] !return_test_clock; endproperty
  a_dn: assert property (p_dn) else $error("return clock late on fall");
  property p_eq; $changed(return_test_clock) |-> return_test_clock == tck; endproperty
  a_eq: assert property (p_eq) else $error("return clock moved wrongly");
  // Exact lag: two sync stages, the edge detector, then the output flop
  sequence s_dn; $fell(tck); endsequence
  sequence s_low4; !return_test_clock [*4]; endsequence
  sequence s_high4; return_test_clock [*4]; endsequence
  property p_lag_up; s_up |-> s_low4 ##1 return_test_clock; endproperty
  a_lag_up: assert property (p_lag_up) else $error("return clock rise lag wrong");
  property p_lag_dn; s_dn |-> s_high4 ##1 !return_test_clock; endproperty
  a_lag_dn: assert property (p_lag_dn) else $error("return clock fall lag wrong");
  // Data out may only move after a recognised falling edge
  property p_tdo; $changed(tdo) |-> !tck; endproperty
  a_tdo: assert property (p_tdo) else $error("data out moved while clock high");
  property p_rst; $rose(arst_n) |-> !return_test_clock && !tdo; endproperty
  a_rst: assert property (p_rst) else $error("outputs not low after reset");
endmodule : mjdc_chain_asserts
bind mjdc_chain mjdc_chain_asserts mjdc_chain_asserts_inst (.clk(clk), .arst_n(arst_n),
  .trst_n(trst_n), .tck(tck), .tms(tms), .tdi(tdi), .return_test_clock(return_test_clock),
  .tdo(tdo));

// ---- verif/mjdc_probe.sv ----
// Purpose: Debug probe model driving the test clock
// Assumes: Return clock answers every edge
// Notes:   Each wait gives up after 40 cycles and counts a miss
`timescale 1ns/1ns
module mjdc_probe (
  input  wire logic clk,
  input  wire logic return_test_clock,
  input  wire logic tdo,
  output logic      tck,
  output logic      tms,
  output logic      tdi
);
  int miss;
  initial
  begin
    miss = 0;
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // A lost answer is counted so the bench can fail instead of drifting on
  task automatic hs(input logic lv);
    for (int n = 0; n < 40 && return_test_clock !== lv; n++)
      @(posedge clk);
    if (return_test_clock !== lv)
      miss++;
  endtask : hs
  // One test clock period; q is data out seen before the fall
  task automatic step(input logic m, input logic d, output logic q);
    @(posedge clk);
    tms <= m;
    tdi <= d;
    @(posedge clk);
    tck <= 1'b1;
    hs(1'b1);
    q = tdo;
    tck <= 1'b0;
    hs(1'b0);
  endtask : step
endmodule : mjdc_probe

// ---- verif/tb_mjdc_chain.sv ----
// Purpose: Bench for the debug scan chain
// Assumes: Probe model drives the clock, mode and data pins; the bench drives trst_n
// Notes:   Whole chain is shifted, so runs are long
`timescale 1ns/1ns
module tb_mjdc_chain;
  logic clk, arst_n, trst_n, tck, tms, tdi, return_test_clock, tdo, q;
  int err_count, check_count;
  logic [575:0] v;
  mjdc_chain mjdc_chain_inst (.clk(clk), .arst_n(arst_n), .trst_n(trst_n), .tck(tck),
    .tms(tms), .tdi(tdi), .return_test_clock(return_test_clock), .tdo(tdo));
  mjdc_probe mjdc_probe_inst (.clk(clk), .return_test_clock(return_test_clock), .tdo(tdo),
    .tck(tck), .tms(tms), .tdi(tdi));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic check(input string s, input logic [71:0] seen, input logic [71:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask : check
  // Mode select pattern, first bit first
  task automatic walk(input logic [3:0] p, input int n);
    for (int i = 0; i < n; i++)
      mjdc_probe_inst.step(p[i], 1'b0, q);
  endtask : walk
  // Shift n bits from the shift state, then update and back to idle
  task automatic shift(input int n, input logic [575:0] din);
    v = '0;
    for (int i = 0; i < n; i++)
    begin
      mjdc_probe_inst.step(i == n - 1, din[i], q);
      v[i] = q;
    end
    walk(4'b0001, 2);
  endtask : shift
  task automatic test_id;
    @(posedge clk);
    trst_n <= 1'b0;
    repeat (4) @(posedge clk);
    trst_n <= 1'b1;
    repeat (4) @(posedge clk);
    walk(4'b0010, 4);
    shift(576, '0);
    for (int c = 0; c < mjdc_pkg::NUM_CORES; c++)
      check("identity", v[c*32 +: 32], mjdc_pkg::ID_CODE);
    check("handshake misses", mjdc_probe_inst.miss, 72'h0);
    $display("test_id done");
  endtask : test_id
  task automatic test_byp(input logic [3:0] ir);
    walk(4'b0011, 4);
    shift(72, {mjdc_pkg::NUM_CORES{ir}});
    check("ir capture", v[71:0], {mjdc_pkg::NUM_CORES{mjdc_pkg::IR_CAPTURE}});
    walk(4'b0001, 3);
    shift(20, 576'h1);
    check("bypass", v[71:0], 72'h40000);
    check("handshake misses", mjdc_probe_inst.miss, 72'h0);
    $display("test_byp done");
  endtask : test_byp
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : finish_test
  initial
  begin
    err_count = 0;
    check_count = 0;
    arst_n = 1'b0;
    trst_n = 1'b0;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    test_id;
    test_byp(mjdc_pkg::IR_BYPASS);
    test_byp(4'h0);
    test_id;
    finish_test;
  end
  initial
  begin
    #3000000;
    err_count++;
    finish_test;
  end
endmodule : tb_mjdc_chain
